// *** hdl/rwc_pkg.sv ***
// Constants for the reset, watchdog and clock control block
// Operation
// - Sleep request bit puts chip to sleep; hardware clears it on wake-up.
// - Cause flags: 00 software, 01 power-on, 10 watchdog, 11 reset pin.
// - Power control bits 3 and 2 are free user flags, reset to zero.
// - Supply low asserts power-on reset, held for the power-on delay.
// - Only power-on reset reloads configuration and clears reset-keep register.
// - Enabled pin high beyond minimum pulse resets; release delay after pin falls.
// - Software reset bit resets chip, holds release delay, self-clears.
// - Software reset updates cause only if bootloader state 0 or watchdog enabled.
// - Software reset clears bootloader state; cause may keep showing power-on.
// - Watchdog is 8-bit up-counter ticked every 65536 clocks, overflow on wrap.
// - Overflow sets read-only flag bit 5; cleared by reload or service entry.
// - Overflow with watchdog reset enabled gives watchdog reset with release delay.
// - Software sets watchdog period by writing a start value to the count.
// - Source feeds 4x PLL; USB clock is PLL/2; system clock divided separately.
// - Bit 7 selects and enables internal oscillator; zero selects crystal.
// - Bit 6 enables crystal oscillator and turns two pins into crystal pins.
// - Bit 4 selects accelerated flash reference clock for slow sources.
// - Bit 3 reads the current level of the reset input pin.
// - Divider select codes give 512,128,32,16,8,6,4,3; reset value 011b.
// - Clock configuration writable only in safe mode opened by 55h then AAh.
// - After reset internal oscillator, 96MHz PLL, 48MHz USB, 6MHz system.
package rwc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLOCK_CFG  = 8'hB9;
    localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
    localparam logic [7:0] IDX_WATCHDOG_COUNT = 8'hFF;
    localparam logic [7:0] IDX_RESET_KEEP = 8'hFE;
    localparam logic [7:0] IDX_GLOBAL_CFG = 8'hB1;
    localparam logic [7:0] IDX_SAFE_MODE  = 8'hA1;
    // Clock configuration fields
    localparam int CC_INT_OSC  = 7;
    localparam int CC_XTAL     = 6;
    localparam int CC_WDOG_FLG = 5;
    localparam int CC_FLASH    = 4;
    localparam int CC_PIN      = 3;
    localparam logic [7:0] CLOCK_CFG_RESET = 8'h83;
    // Power control fields
    localparam int PC_CAUSE_HI = 5;
    localparam int PC_CAUSE_LO = 4;
    localparam int PC_FLAG_HI  = 3;
    localparam int PC_FLAG_LO  = 2;
    localparam int PC_SLEEP    = 1;
    // Global configuration fields
    localparam int GC_WDOG_EN  = 0;
    localparam int GC_SW_RESET = 4;
    localparam int GC_BOOT     = 5;
    // Last reset cause codes
    localparam logic [1:0] CAUSE_SW   = 2'h0;
    localparam logic [1:0] CAUSE_POR  = 2'h1;
    localparam logic [1:0] CAUSE_WDOG = 2'h2;
    localparam logic [1:0] CAUSE_PIN  = 2'h3;
    // Safe mode keys
    localparam logic [7:0] SAFE_KEY1 = 8'h55;
    localparam logic [7:0] SAFE_KEY2 = 8'hAA;
    // PLL multiplier, USB divider and system divider table
    localparam logic [2:0] PLL_MULT = 3'h4;
    localparam logic [1:0] USB_DIV  = 2'h2;
    localparam logic [9:0] SYS_DIV0 = 10'h200;
    localparam logic [9:0] SYS_DIV1 = 10'h080;
    localparam logic [9:0] SYS_DIV2 = 10'h020;
    localparam logic [9:0] SYS_DIV3 = 10'h010;
    localparam logic [9:0] SYS_DIV4 = 10'h008;
    localparam logic [9:0] SYS_DIV5 = 10'h006;
    localparam logic [9:0] SYS_DIV6 = 10'h004;
    localparam logic [9:0] SYS_DIV7 = 10'h003;
    // Timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int POR_HOLD_NS    = 20480;
    localparam int RELEASE_NS     = 5120;
    localparam int PIN_MIN_NS     = 320;
    localparam int POR_HOLD_CYC   =
        (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC    =
        (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_MIN_CYC    =
        (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDOG_PRESCALE  = 65536;
    localparam int TIMER_W        = 12;
endpackage : rwc_pkg

// *** hdl/rwc_hold_timer.sv ***
// Down-counter that times the reset hold intervals
`timescale 1ns/1ps
module rwc_hold_timer #(
    parameter int W         = 12,
    parameter int RESET_CNT = 1024
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              busy
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // Reload wins over counting so a repeated cause restarts the hold
    always_comb begin
        count_nxt = count_r;
        if (load) begin
            count_nxt = load_value;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // Power-up starts with the power-on hold already armed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= W'(RESET_CNT);
        end else begin
            count_r <= count_nxt;
        end
    end

    assign busy = (count_r != '0);
endmodule : rwc_hold_timer

// *** hdl/rwc_reset_watchdog_clock_ctrl.sv ***
// Reset sequencer, watchdog and clock configuration with Avalon-MM slave
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module rwc_reset_watchdog_clock_ctrl #(
    parameter int POR_CYC   = rwc_pkg::POR_HOLD_CYC,
    parameter int REL_CYC   = rwc_pkg::RELEASE_CYC,
    parameter int PIN_CYC   = rwc_pkg::PIN_MIN_CYC,
    parameter int PRESCALE  = rwc_pkg::WDOG_PRESCALE
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        vcc_low,
    input  wire logic        reset_pin,
    input  wire logic        ext_reset_enable,
    input  wire logic        boot_strap,
    input  wire logic        wake_event,
    input  wire logic        wdog_irq_ack,
    output logic             cpu_reset_n,
    output logic             config_reload,
    output logic             sleep_active,
    output logic             wdog_irq_flag,
    output logic             internal_osc_enable,
    output logic             crystal_osc_enable,
    output logic             crystal_pin_mode,
    output logic             flash_clock_accelerate,
    output logic      [2:0]  pll_multiplier,
    output logic      [1:0]  usb_clock_divisor,
    output logic      [9:0]  sys_clock_divisor
);
    localparam int TW    = rwc_pkg::TIMER_W;
    localparam int PRE_W = $clog2(PRESCALE);

    typedef enum logic [1:0] {
        RWC_RUN, RWC_POR_HOLD, RWC_PIN_ASSERT, RWC_WARM_HOLD
    } rwc_state_t;
    typedef enum logic [1:0] {
        RWC_LOCKED, RWC_KEY1_SEEN, RWC_OPEN
    } rwc_safe_t;

    rwc_state_t        state_r, state_nxt;
    rwc_safe_t         safe_r, safe_nxt;
    logic              wait_r, wait_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              cpu_rst_n_r, cpu_rst_n_nxt;
    logic              reload_r, reload_nxt;
    logic [1:0]        cause_r, cause_nxt;
    logic              boot_r, boot_nxt;
    logic              wdog_en_r, wdog_en_nxt;
    logic              sw_rst_r, sw_rst_nxt;
    logic              sleep_r, sleep_nxt;
    logic [1:0]        uflag_r, uflag_nxt;
    logic [7:0]        keep_r, keep_nxt;
    logic [7:0]        wcount_r, wcount_nxt;
    logic [PRE_W-1:0]  pre_r, pre_nxt;
    logic              wflag_r, wflag_nxt;
    logic              osc_int_r, osc_int_nxt;
    logic              xtal_r, xtal_nxt;
    logic              fast_r, fast_nxt;
    logic [2:0]        div_r, div_nxt;
    logic [9:0]        sdiv_r, sdiv_nxt;
    logic [TW-1:0]     pin_cnt_r, pin_cnt_nxt;
    logic              tmr_load;
    logic [TW-1:0]     tmr_value;
    logic              tmr_busy;
    logic [7:0]        idx;
    logic [7:0]        wbyte;
    logic              wr_take;
    logic              wdog_tick;
    logic              wdog_wrap;
    logic              warm_go;

    assign idx       = avs_address[9:2];
    assign wbyte     = avs_writedata[7:0];
    assign wr_take   = avs_write && !wait_r;
    assign wdog_tick = (pre_r == PRE_W'(PRESCALE - 1));
    assign wdog_wrap = wdog_tick && (wcount_r == 8'hFF);

    // Hold interval counter shared by every reset source
    rwc_hold_timer #(
        .W         (TW),
        .RESET_CNT (POR_CYC)
    ) u_hold (
        .clk        (clk),
        .reset_n    (reset_n),
        .load       (tmr_load),
        .load_value (tmr_value),
        .busy       (tmr_busy)
    );

    // Divider code to PLL division ratio
    function automatic logic [9:0] sys_div(input logic [2:0] code);
        case (code)
            3'h0:    sys_div = rwc_pkg::SYS_DIV0;
            3'h1:    sys_div = rwc_pkg::SYS_DIV1;
            3'h2:    sys_div = rwc_pkg::SYS_DIV2;
            3'h3:    sys_div = rwc_pkg::SYS_DIV3;
            3'h4:    sys_div = rwc_pkg::SYS_DIV4;
            3'h5:    sys_div = rwc_pkg::SYS_DIV5;
            3'h6:    sys_div = rwc_pkg::SYS_DIV6;
            default: sys_div = rwc_pkg::SYS_DIV7;
        endcase
    endfunction : sys_div

    // Reset sequencer: power-on beats all, then pin, watchdog, software
    always_comb begin
        state_nxt   = state_r;
        cause_nxt   = cause_r;
        boot_nxt    = boot_r;
        reload_nxt  = 1'b0;
        pin_cnt_nxt = '0;
        tmr_load    = 1'b0;
        tmr_value   = TW'(REL_CYC);
        warm_go     = 1'b0;
        if (vcc_low) begin
            state_nxt  = RWC_POR_HOLD;
            cause_nxt  = rwc_pkg::CAUSE_POR;
            tmr_load   = 1'b1;
            tmr_value  = TW'(POR_CYC);
        end else begin
            case (state_r)
                RWC_POR_HOLD: begin
                    if (!tmr_busy) begin
                        state_nxt  = RWC_RUN;
                        reload_nxt = 1'b1;
                        boot_nxt   = boot_strap;
                    end
                end
                RWC_PIN_ASSERT: begin
                    if (!reset_pin) begin
                        state_nxt = RWC_WARM_HOLD;
                        tmr_load  = 1'b1;
                    end
                end
                RWC_WARM_HOLD: begin
                    if (!tmr_busy) begin
                        state_nxt = RWC_RUN;
                    end
                end
                default: begin
                    if (ext_reset_enable && reset_pin) begin
                        pin_cnt_nxt = pin_cnt_r + 1'b1;
                    end
                    if (pin_cnt_r >= TW'(PIN_CYC)) begin
                        state_nxt = RWC_PIN_ASSERT;
                        cause_nxt = rwc_pkg::CAUSE_PIN;
                        warm_go   = 1'b1;
                    end else if (wdog_wrap && wdog_en_r) begin
                        state_nxt = RWC_WARM_HOLD;
                        cause_nxt = rwc_pkg::CAUSE_WDOG;
                        tmr_load  = 1'b1;
                        warm_go   = 1'b1;
                    end else if (sw_rst_r) begin
                        state_nxt = RWC_WARM_HOLD;
                        tmr_load  = 1'b1;
                        warm_go   = 1'b1;
                        boot_nxt  = 1'b0;
                        if (!boot_r || wdog_en_r) begin
                            cause_nxt = rwc_pkg::CAUSE_SW;
                        end
                    end
                end
            endcase
        end
        cpu_rst_n_nxt = (state_nxt == RWC_RUN);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= RWC_POR_HOLD;
            cause_r     <= rwc_pkg::CAUSE_POR;
            boot_r      <= 1'b0;
            reload_r    <= 1'b0;
            pin_cnt_r   <= '0;
            cpu_rst_n_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cause_r     <= cause_nxt;
            boot_r      <= boot_nxt;
            reload_r    <= reload_nxt;
            pin_cnt_r   <= pin_cnt_nxt;
            cpu_rst_n_r <= cpu_rst_n_nxt;
        end
    end

    // Bus answer and register file; reset entry restores warm defaults
    always_comb begin
        wait_nxt    = 1'b1;
        rdata_nxt   = rdata_r;
        safe_nxt    = safe_r;
        wdog_en_nxt = wdog_en_r;
        sw_rst_nxt  = sw_rst_r;
        sleep_nxt   = sleep_r;
        uflag_nxt   = uflag_r;
        keep_nxt    = keep_r;
        osc_int_nxt = osc_int_r;
        xtal_nxt    = xtal_r;
        fast_nxt    = fast_r;
        div_nxt     = div_r;
        pre_nxt     = wdog_tick ? '0 : pre_r + 1'b1; // Exact for any ratio
        wcount_nxt  = wdog_tick ? wcount_r + 1'b1 : wcount_r;
        wflag_nxt   = wflag_r;
        // One wait cycle, then the answer stands for the taking edge
        if ((avs_read || avs_write) && wait_r) begin
            wait_nxt  = 1'b0;
            rdata_nxt = 32'h0000_0000;
            case (idx)
                rwc_pkg::IDX_CLOCK_CFG: rdata_nxt[7:0] = {osc_int_r, xtal_r,
                    wflag_r, fast_r, reset_pin, div_r};
                rwc_pkg::IDX_POWER_CTRL: rdata_nxt[7:0] = {2'h0, cause_r,
                    uflag_r, sleep_r, 1'b0};
                rwc_pkg::IDX_WATCHDOG_COUNT: rdata_nxt[7:0] = wcount_r;
                rwc_pkg::IDX_RESET_KEEP: rdata_nxt[7:0] = keep_r;
                rwc_pkg::IDX_GLOBAL_CFG: rdata_nxt[7:0] = {2'h0, boot_r,
                    sw_rst_r, 3'h0, wdog_en_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // Hardware wake clears sleep; a software set in that cycle wins
        if (wake_event) begin
            sleep_nxt = 1'b0;
        end
        if (wdog_irq_ack) begin
            wflag_nxt = 1'b0;
        end
        if (wr_take) begin
            case (idx)
                rwc_pkg::IDX_SAFE_MODE: begin
                    if (wbyte == rwc_pkg::SAFE_KEY1) begin
                        safe_nxt = RWC_KEY1_SEEN;
                    end else if (wbyte == rwc_pkg::SAFE_KEY2 &&
                                 safe_r == RWC_KEY1_SEEN) begin
                        safe_nxt = RWC_OPEN;
                    end else begin
                        safe_nxt = RWC_LOCKED;
                    end
                end
                rwc_pkg::IDX_CLOCK_CFG: begin
                    if (safe_r == RWC_OPEN) begin
                        osc_int_nxt = wbyte[rwc_pkg::CC_INT_OSC];
                        xtal_nxt    = wbyte[rwc_pkg::CC_XTAL];
                        fast_nxt    = wbyte[rwc_pkg::CC_FLASH];
                        div_nxt     = wbyte[2:0];
                    end
                end
                rwc_pkg::IDX_POWER_CTRL: begin
                    uflag_nxt = wbyte[rwc_pkg::PC_FLAG_HI:rwc_pkg::PC_FLAG_LO];
                    if (wbyte[rwc_pkg::PC_SLEEP]) begin
                        sleep_nxt = 1'b1;
                    end
                end
                rwc_pkg::IDX_WATCHDOG_COUNT: begin
                    wcount_nxt = wbyte;
                    wflag_nxt  = 1'b0;
                end
                rwc_pkg::IDX_RESET_KEEP: keep_nxt = wbyte;
                rwc_pkg::IDX_GLOBAL_CFG: begin
                    wdog_en_nxt = wbyte[rwc_pkg::GC_WDOG_EN];
                    if (wbyte[rwc_pkg::GC_SW_RESET]) begin
                        sw_rst_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Overflow sets the flag even against a same-cycle clear
        if (wdog_wrap) begin
            wflag_nxt = 1'b1;
        end
        if (warm_go || vcc_low) begin
            safe_nxt    = RWC_LOCKED;
            wdog_en_nxt = 1'b0;
            sw_rst_nxt  = 1'b0;
            sleep_nxt   = 1'b0;
            uflag_nxt   = 2'h0;
            wcount_nxt  = 8'h00;
            pre_nxt     = '0;
            wflag_nxt   = 1'b0;
            osc_int_nxt = rwc_pkg::CLOCK_CFG_RESET[rwc_pkg::CC_INT_OSC];
            xtal_nxt    = rwc_pkg::CLOCK_CFG_RESET[rwc_pkg::CC_XTAL];
            fast_nxt    = rwc_pkg::CLOCK_CFG_RESET[rwc_pkg::CC_FLASH];
            div_nxt     = rwc_pkg::CLOCK_CFG_RESET[2:0];
        end
        if (vcc_low) begin
            keep_nxt = 8'h00;
        end
        sdiv_nxt = sys_div(div_nxt);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r    <= 1'b1;
            rdata_r   <= 32'h0000_0000;
            safe_r    <= RWC_LOCKED;
            wdog_en_r <= 1'b0;
            sw_rst_r  <= 1'b0;
            sleep_r   <= 1'b0;
            uflag_r   <= 2'h0;
            keep_r    <= 8'h00;
            pre_r     <= '0;
            wcount_r  <= 8'h00;
            wflag_r   <= 1'b0;
            osc_int_r <= rwc_pkg::CLOCK_CFG_RESET[rwc_pkg::CC_INT_OSC];
            xtal_r    <= rwc_pkg::CLOCK_CFG_RESET[rwc_pkg::CC_XTAL];
            fast_r    <= rwc_pkg::CLOCK_CFG_RESET[rwc_pkg::CC_FLASH];
            div_r     <= rwc_pkg::CLOCK_CFG_RESET[2:0];
            sdiv_r    <= rwc_pkg::SYS_DIV3;
        end else begin
            wait_r    <= wait_nxt;
            rdata_r   <= rdata_nxt;
            safe_r    <= safe_nxt;
            wdog_en_r <= wdog_en_nxt;
            sw_rst_r  <= sw_rst_nxt;
            sleep_r   <= sleep_nxt;
            uflag_r   <= uflag_nxt;
            keep_r    <= keep_nxt;
            pre_r     <= pre_nxt;
            wcount_r  <= wcount_nxt;
            wflag_r   <= wflag_nxt;
            osc_int_r <= osc_int_nxt;
            xtal_r    <= xtal_nxt;
            fast_r    <= fast_nxt;
            div_r     <= div_nxt;
            sdiv_r    <= sdiv_nxt;
        end
    end

    // Outputs straight from flip-flops; PLL and USB ratios are fixed
    assign avs_readdata           = rdata_r;
    assign avs_waitrequest        = wait_r;
    assign cpu_reset_n            = cpu_rst_n_r;
    assign config_reload          = reload_r;
    assign sleep_active           = sleep_r;
    assign wdog_irq_flag          = wflag_r;
    assign internal_osc_enable    = osc_int_r;
    assign crystal_osc_enable     = xtal_r;
    assign crystal_pin_mode       = xtal_r;
    assign flash_clock_accelerate = fast_r;
    assign sys_clock_divisor      = sdiv_r;
    assign pll_multiplier         = rwc_pkg::PLL_MULT;
    assign usb_clock_divisor      = rwc_pkg::USB_DIV;

    // Checks on the sequencer, watchdog and configuration lock
    cpu_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r != RWC_RUN) |-> !cpu_reset_n)
        else $error("core released while a reset is held");
    por_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        vcc_low |=> (state_r == RWC_POR_HOLD && cause_r == 2'h1))
        else $error("supply low did not start power-on hold");
    keep_warm_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!vcc_low && !(wr_take && idx == rwc_pkg::IDX_RESET_KEEP))
        |=> $stable(keep_r))
        else $error("reset keep register changed without cause");
    sw_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == RWC_RUN && sw_rst_r && boot_r && !wdog_en_r &&
         !vcc_low && !wdog_wrap && pin_cnt_r < TW'(PIN_CYC))
        |=> ($stable(cause_r) && !boot_r && state_r == RWC_WARM_HOLD))
        else $error("software reset handled cause or boot state wrongly");
    wdog_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wdog_wrap && !wdog_en_r && !vcc_low && !warm_go &&
         !(wr_take && idx == rwc_pkg::IDX_WATCHDOG_COUNT))
        |=> (wcount_r == 8'h00 && wdog_irq_flag))
        else $error("watchdog wrap did not clear count and set flag");
    wdog_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == RWC_RUN && wdog_wrap && wdog_en_r && !vcc_low &&
         pin_cnt_r < TW'(PIN_CYC))
        |=> (!cpu_reset_n && cause_r == 2'h2) [*2])
        else $error("watchdog reset not taken");
    cfg_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
        (safe_r != RWC_OPEN && !warm_go && !vcc_low)
        |=> $stable({osc_int_r, xtal_r, fast_r, div_r}))
        else $error("clock configuration changed while locked");
    pin_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == RWC_PIN_ASSERT && !reset_pin && !vcc_low)
        |=> (state_r == RWC_WARM_HOLD) ##1 tmr_busy)
        else $error("pin release did not start release hold");
    sleep_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        (sleep_r && wake_event && !wr_take) |=> !sleep_active)
        else $error("wake did not clear sleep request");
    wait_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
endmodule : rwc_reset_watchdog_clock_ctrl

// *** verif/rwc_pin_model.sv ***
// External reset pin model: drives one high pulse of a chosen length
`timescale 1ns/1ps
module rwc_pin_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic [7:0] length,
    output logic            reset_pin
);
    logic [7:0] left_r;
    // Pulse length counter; a long pulse exceeds the minimum width
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) left_r <= 8'h00;
        else if (start) left_r <= length;
        else if (left_r != 8'h00) left_r <= left_r - 8'h01;
    end
    assign reset_pin = (left_r != 8'h00);
endmodule : rwc_pin_model

// *** verif/tb_rwc_reset_watchdog_clock_ctrl.sv ***
// Testbench for the reset, watchdog and clock control block
`timescale 1ns/1ps
module tb_rwc_reset_watchdog_clock_ctrl;
    logic        clk, reset_n, avs_read, avs_write, vcc_low, ena, boot;
    logic        wake, ack, go, pin, cpu_n, reload, flag, sl, io, xo, xp;
    logic        fa, avs_waitrequest;
    logic [2:0]  pm;
    logic [1:0]  ud;
    logic [7:0]  len;
    logic [9:0]  avs_address, div;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [9:0]  dv [8] = '{10'h200, 10'h080, 10'h020, 10'h010,
                            10'h008, 10'h006, 10'h004, 10'h003};
    int          errors, comparisons;
    rwc_reset_watchdog_clock_ctrl #(.POR_CYC(8), .REL_CYC(4), .PIN_CYC(2),
        .PRESCALE(4)) rwc_reset_watchdog_clock_ctrl_inst (.clk(clk),
        .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .vcc_low(vcc_low), .reset_pin(pin), .ext_reset_enable(ena),
        .boot_strap(boot), .wake_event(wake), .wdog_irq_ack(ack),
        .cpu_reset_n(cpu_n), .config_reload(reload), .sleep_active(sl),
        .wdog_irq_flag(flag), .internal_osc_enable(io),
        .crystal_osc_enable(xo), .crystal_pin_mode(xp),
        .flash_clock_accelerate(fa), .pll_multiplier(pm),
        .usb_clock_divisor(ud), .sys_clock_divisor(div));
    rwc_pin_model rwc_pin_model_inst (.clk(clk), .reset_n(reset_n),
        .start(go), .length(len), .reset_pin(pin));
    // Free-running 50 MHz clock
    always #10 clk = ~clk;
    task automatic results;
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // One bus cycle; held until waitrequest is seen low, then released
    task automatic bus(input logic w, input logic [7:0] i, d);
        int n;
        @(posedge clk);
        avs_address <= {i, 2'h0};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        n = 0;
        // Pre-edge values seen here: the answer standing at this edge
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 99);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(negedge clk);
        if (n >= 99) begin errors++; results(); end
    endtask : bus
    task automatic wr(input logic [7:0] i, d);
        bus(1'h1, i, d);
    endtask : wr
    task automatic rd(input string n, input logic [7:0] i, e);
        bus(1'h0, i, 8'h00);
        chk(n, q, {24'h0, e});
    endtask : rd
    // Bounded wait for a level on a design or pin model output
    task automatic wt(ref logic s, input logic v);
        int n;
        for (n = 0; n < 3000 && s !== v; n++) @(negedge clk);
        if (s !== v) begin errors++; results(); end
    endtask : wt
    initial begin
        {clk, reset_n, avs_read, avs_write, vcc_low, ena, boot} = '0;
        {wake, ack, go, len, avs_address, avs_writedata} = '0;
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        wt(cpu_n, 1'h1);
        rd("cfg", 8'hB9, 8'h83);
        chk("pll", {pm, ud, div}, {3'h4, 2'h2, 10'h010});
        rd("pwr", 8'h87, 8'h10);
        wr(8'hB9, 8'h50);
        rd("lock", 8'hB9, 8'h83);
        wr(8'hA1, 8'h55);
        wr(8'hA1, 8'hAA);
        for (int c = 0; c < 8; c++) begin
            wr(8'hB9, 8'h50 | 8'(c));
            chk("div", div, dv[c]);
        end
        chk("osc", {io, xo, xp, fa}, 4'h7);
        wr(8'hA1, 8'h00);
        wr(8'hB9, 8'h83);
        rd("close", 8'hB9, 8'h57);
        wr(8'h87, 8'h0E);
        chk("sleep", sl, 1'h1);
        rd("flags", 8'h87, 8'h1E);
        @(posedge clk);
        wake <= 1'h1;
        @(posedge clk);
        wake <= 1'h0;
        rd("wake", 8'h87, 8'h1C);
        wr(8'hFE, 8'h5A);
        // Pin high with pin reset disabled only shows in the status bit
        @(posedge clk);
        len <= 8'h28;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        rd("pin", 8'hB9, 8'h5F);
        wt(pin, 1'h0);
        @(posedge clk);
        ena <= 1'h1;
        len <= 8'h0A;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        wt(cpu_n, 1'h0);
        wt(cpu_n, 1'h1);
        rd("pinrst", 8'h87, 8'h30);
        rd("keep", 8'hFE, 8'h5A);
        wr(8'hFF, 8'hFF);
        wt(flag, 1'h1);
        rd("wdflag", 8'hB9, 8'hA3);
        @(posedge clk);
        ack <= 1'h1;
        @(posedge clk);
        ack <= 1'h0;
        @(negedge clk);
        chk("ack", flag, 1'h0);
        wr(8'hFF, 8'hFF);
        wt(flag, 1'h1);
        wr(8'hFF, 8'h10);
        chk("reload", flag, 1'h0);
        wr(8'hB1, 8'h01);
        wr(8'hFF, 8'hFE);
        wt(cpu_n, 1'h0);
        wt(cpu_n, 1'h1);
        rd("wdrst", 8'h87, 8'h20);
        wr(8'hB1, 8'h10);
        wt(cpu_n, 1'h0);
        wt(cpu_n, 1'h1);
        rd("swrst", 8'h87, 8'h00);
        rd("swbit", 8'hB1, 8'h00);
        @(posedge clk);
        boot <= 1'h1;
        vcc_low <= 1'h1;
        @(posedge clk);
        vcc_low <= 1'h0;
        wt(reload, 1'h1);
        wt(cpu_n, 1'h1);
        rd("por", 8'h87, 8'h10);
        rd("porkeep", 8'hFE, 8'h00);
        rd("boot", 8'hB1, 8'h20);
        wr(8'hB1, 8'h10);
        wt(cpu_n, 1'h0);
        wt(cpu_n, 1'h1);
        rd("bootrst", 8'h87, 8'h10);
        rd("app", 8'hB1, 8'h00);
        // Crystal switch: enable it first, settle, then drop internal
        wr(8'hA1, 8'h55);
        wr(8'hA1, 8'hAA);
        rd("xt0", 8'hB9, 8'h83);
        wr(8'hB9, q[7:0] | 8'h40);
        repeat (10) @(negedge clk);
        chk("xten", {io, xo, xp}, 3'h7);
        wr(8'hA1, 8'h55);
        wr(8'hA1, 8'hAA);
        rd("xt1", 8'hB9, 8'hC3);
        wr(8'hB9, q[7:0] & 8'h7F);
        wr(8'hA1, 8'h00);
        chk("xtal", {io, xo, xp}, 3'h3);
        results();
    end
endmodule : tb_rwc_reset_watchdog_clock_ctrl
